// >>> mmb_cfg.svh
// Address map, widths and reset values of the muxed bus slave
`ifndef MMB_CFG_SVH
`define MMB_CFG_SVH
`define MMB_ADDR_W 8
`define MMB_DATA_W 8
`define MMB_SYNC_STAGES 2
`define MMB_STROBE_N 4
`define MMB_DEV_SELECT_VALUE 8'h00
`define MMB_STATUS_ADDR 8'h80
`define MMB_CTRL_ADDR 8'h82
`define MMB_DATAIN_ADDR 8'h84
`define MMB_DATAOUT_ADDR 8'h86
`define MMB_BYTE_ZERO 8'h00
`define MMB_STROBE_IDLE 4'hf
`define MMB_IDX_ALE 0
`define MMB_IDX_RD 1
`define MMB_IDX_WR 2
`define MMB_IDX_FETCH 3
`endif

// >>> mmb_pkg.sv
// Types shared by the muxed bus slave
package mmb_pkg;
    typedef enum logic [1:0] {
        MMB_IDLE = 2'b00,
        MMB_DECODE = 2'b01,
        MMB_TRANSFER_STATE = 2'b10,
        MMB_END_CYCLE = 2'b11
    } mmb_state_e;
    typedef logic [7:0] mmb_byte_t;
endpackage

// >>> mmb_strobe_if.sv
// Synchronised host strobes passed to the bus state machine
interface mmb_strobe_if;
    logic ale_n;
    logic rd_n;
    logic wr_n;
    logic program_fetch_strobe_n;
    modport src (output ale_n, output rd_n, output wr_n, output program_fetch_strobe_n);
    modport dst (input ale_n, input rd_n, input wr_n, input program_fetch_strobe_n);
endinterface

// >>> mmb_sync.sv
// Two-stage synchroniser for the host strobes
`include "mmb_cfg.svh"
module mmb_sync (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [`MMB_STROBE_N-1:0] strobe_n_i,
    mmb_strobe_if.src sync_o
);
    logic [`MMB_STROBE_N-1:0] meta_reg;
    logic [`MMB_STROBE_N-1:0] sync_reg;

    // Strobes idle high so reset to negated
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= `MMB_STROBE_IDLE;
            sync_reg <= `MMB_STROBE_IDLE;
        end else begin
            meta_reg <= strobe_n_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o.ale_n = sync_reg[`MMB_IDX_ALE];
    assign sync_o.rd_n = sync_reg[`MMB_IDX_RD];
    assign sync_o.wr_n = sync_reg[`MMB_IDX_WR];
    assign sync_o.program_fetch_strobe_n = sync_reg[`MMB_IDX_FETCH];
endmodule

// >>> mmb_top.sv
// Register file slave on a multiplexed address/data host bus
`include "mmb_cfg.svh"
module mmb_top (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_hi_i,
    input wire logic [7:0] low_port_i,
    output logic [7:0] low_port_o,
    output logic low_port_oe_o,
    input wire logic ale_n_i,
    input wire logic program_fetch_strobe_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    output logic int_n_o,
    input wire logic app_irq_i,
    input wire logic [7:0] app_status_i,
    input wire logic [7:0] app_dataout_i,
    input wire logic app_dataout_we_i,
    output logic [7:0] ctrl_o,
    output logic [7:0] datain_o,
    output logic datain_wr_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Strobe synchronisers
    mmb_strobe_if strobe_if ();

    mmb_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .strobe_n_i({program_fetch_strobe_n_i, wr_n_i, rd_n_i, ale_n_i}),
        .sync_o(strobe_if.src)
    );

    mmb_pkg::mmb_state_e state_reg;
    mmb_pkg::mmb_state_e state_next;
    mmb_pkg::mmb_byte_t addr_lo_reg;
    mmb_pkg::mmb_byte_t addr_hi_reg;
    mmb_pkg::mmb_byte_t rdata_reg;
    mmb_pkg::mmb_byte_t rdata_next;
    mmb_pkg::mmb_byte_t status_reg;
    mmb_pkg::mmb_byte_t ctrl_reg;
    mmb_pkg::mmb_byte_t datain_reg;
    mmb_pkg::mmb_byte_t dataout_reg;
    logic ale_prev_reg;
    logic datain_wr_reg;
    logic int_n_reg;
    logic dev_sel;
    logic strobe_on;
    logic go_xfer;
    logic is_write;
    logic en_status;
    logic en_ctrl;
    logic en_datain;
    logic en_dataout;

    ////////////////////////////////////////////////////////////////////////////
    // Address capture and decode
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ale_prev_reg <= 1'b1;
            addr_lo_reg <= `MMB_BYTE_ZERO;
            addr_hi_reg <= `MMB_BYTE_ZERO;
        end else begin
            ale_prev_reg <= ale_n_i;
            if (ale_prev_reg && !ale_n_i) begin
                addr_lo_reg <= low_port_i;
                addr_hi_reg <= addr_hi_i;
            end
        end
    end

    assign dev_sel = (addr_hi_reg == `MMB_DEV_SELECT_VALUE);
    // Even addresses only, four registers
    assign en_status = (addr_lo_reg == `MMB_STATUS_ADDR);
    assign en_ctrl = (addr_lo_reg == `MMB_CTRL_ADDR);
    assign en_datain = (addr_lo_reg == `MMB_DATAIN_ADDR);
    assign en_dataout = (addr_lo_reg == `MMB_DATAOUT_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // Bus state machine
    assign strobe_on = !strobe_if.rd_n || !strobe_if.wr_n;
    assign is_write = !strobe_if.wr_n;
    assign go_xfer = dev_sel && strobe_on && strobe_if.program_fetch_strobe_n;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mmb_pkg::MMB_IDLE: begin
                if (!strobe_if.ale_n) begin
                    state_next = mmb_pkg::MMB_DECODE;
                end
            end
            mmb_pkg::MMB_DECODE: begin
                if (go_xfer) begin
                    state_next = mmb_pkg::MMB_TRANSFER_STATE;
                end else if (strobe_if.ale_n) begin
                    state_next = mmb_pkg::MMB_IDLE;
                end
            end
            mmb_pkg::MMB_TRANSFER_STATE: begin
                if (!strobe_on) begin
                    state_next = mmb_pkg::MMB_END_CYCLE;
                end
            end
            mmb_pkg::MMB_END_CYCLE: begin
                if (strobe_if.ale_n) begin
                    state_next = mmb_pkg::MMB_IDLE;
                end
            end
            default: begin
                state_next = mmb_pkg::MMB_IDLE;
            end
        endcase
    end

    // No wait output exists; every state advances on host strobes only
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= mmb_pkg::MMB_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer and bus drive
    always_comb begin
        rdata_next = `MMB_BYTE_ZERO;
        if (en_status) begin
            rdata_next = status_reg;
        end else if (en_ctrl) begin
            rdata_next = ctrl_reg;
        end else if (en_datain) begin
            rdata_next = datain_reg;
        end else if (en_dataout) begin
            rdata_next = dataout_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= `MMB_BYTE_ZERO;
        end else if (state_reg == mmb_pkg::MMB_DECODE && go_xfer && !is_write) begin
            rdata_reg <= rdata_next;
        end
    end

    assign low_port_o = rdata_reg;
    assign low_port_oe_o = (state_reg == mmb_pkg::MMB_TRANSFER_STATE)
        && !strobe_if.rd_n;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= `MMB_BYTE_ZERO;
            datain_reg <= `MMB_BYTE_ZERO;
            datain_wr_reg <= 1'b0;
        end else begin
            datain_wr_reg <= 1'b0;
            if (state_reg == mmb_pkg::MMB_DECODE && go_xfer && is_write) begin
                if (en_ctrl) begin
                    ctrl_reg <= low_port_i;
                end
                if (en_datain) begin
                    datain_reg <= low_port_i;
                    datain_wr_reg <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_reg <= `MMB_BYTE_ZERO;
            dataout_reg <= `MMB_BYTE_ZERO;
        end else begin
            status_reg <= app_status_i;
            if (app_dataout_we_i) begin
                dataout_reg <= app_dataout_i;
            end
        end
    end

    assign ctrl_o = ctrl_reg;
    assign datain_o = datain_reg;
    assign datain_wr_o = datain_wr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            int_n_reg <= 1'b1;
        end else begin
            int_n_reg <= !app_irq_i;
        end
    end

    assign int_n_o = int_n_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    a_idle_to_decode: assert property (
        state_reg == mmb_pkg::MMB_IDLE && !strobe_if.ale_n |=> state_reg == mmb_pkg::MMB_DECODE)
        else $error("idle did not move to decode");
    a_decode_to_xfer: assert property (
        state_reg == mmb_pkg::MMB_DECODE && go_xfer |=> state_reg == mmb_pkg::MMB_TRANSFER_STATE)
        else $error("decode did not enter transfer");
    a_unselected_no_xfer: assert property (
        state_reg == mmb_pkg::MMB_DECODE && !dev_sel |=> state_reg != mmb_pkg::MMB_TRANSFER_STATE)
        else $error("transfer entered while not selected");
    a_drive_after_rd: assert property (
        low_port_oe_o |-> !strobe_if.rd_n && !$past(rd_n_i, 2)
        && $past(state_reg) != mmb_pkg::MMB_IDLE)
        else $error("bus driven without read strobe");
    a_strobe_release: assert property (
        state_reg == mmb_pkg::MMB_TRANSFER_STATE && !strobe_on
        |=> state_reg == mmb_pkg::MMB_END_CYCLE && !low_port_oe_o)
        else $error("strobe release did not end transfer");
    a_end_to_idle: assert property (
        state_reg == mmb_pkg::MMB_END_CYCLE && strobe_if.ale_n |=> state_reg == mmb_pkg::MMB_IDLE)
        else $error("end cycle did not return to idle");
    a_addr_capture: assert property (
        $fell(ale_n_i) |=> addr_lo_reg == $past(low_port_i))
        else $error("low address not captured");
    a_ctrl_write: assert property (
        state_reg == mmb_pkg::MMB_DECODE && go_xfer && is_write && en_ctrl
        |=> ctrl_reg == $past(low_port_i) ##1 ctrl_o == $past(low_port_i, 2))
        else $error("control write lost");
    a_read_data: assert property (
        state_reg == mmb_pkg::MMB_DECODE && go_xfer && !is_write && en_ctrl
        |=> low_port_o == ctrl_reg)
        else $error("read data does not match register");
    a_irq_follow: assert property (
        app_irq_i |=> !int_n_o)
        else $error("interrupt not asserted");
endmodule

// >>> mmb_host_model.sv
// Host model driving the muxed address/data bus and strobes
module mmb_host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_i,
    output logic ale_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic fetch_n_o,
    output logic [7:0] addr_hi_o,
    output logic [7:0] bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_oe = 1'b0;
    logic [7:0] host_d = 8'h00;
    logic [7:0] last_q = 8'h00;
    initial begin
        ale_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        fetch_n_o = 1'b1;
        addr_hi_o = 8'h00;
    end
    // Released bus shows a level that flips every cycle
    always_comb bus_o = dev_oe_i ? dev_data_i : (host_oe ? host_d : ~last_q);
    always @(negedge clk_sys_i) last_q <= bus_o;
    ////////////////////////////////////////////////////////////////////////
    // One fixed-timing bus cycle, no handshake
    task automatic cycle(input logic wr, input logic [7:0] hi, input logic [7:0] lo,
            input logic [7:0] wdata, input logic fetch_n, output logic [7:0] rdata,
            output logic early, output logic seen, output logic late);
        early = 1'b0;
        seen = 1'b0;
        @(negedge clk_sys_i);
        addr_hi_o = hi;
        host_d = lo;
        host_oe = 1'b1;
        fetch_n_o = fetch_n;
        ale_n_o = 1'b0;
        repeat (4) begin
            @(negedge clk_sys_i);
            early |= dev_oe_i;
        end
        host_d = wdata;
        host_oe = wr;
        @(negedge clk_sys_i);
        early |= dev_oe_i;
        if (wr) wr_n_o = 1'b0;
        else rd_n_o = 1'b0;
        repeat (6) begin
            @(negedge clk_sys_i);
            seen |= dev_oe_i;
        end
        rdata = bus_o;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        late = dev_oe_i;
        host_oe = 1'b0;
        ale_n_o = 1'b1;
        fetch_n_o = 1'b1;
        repeat (4) @(negedge clk_sys_i);
    endtask
endmodule

// >>> tb.sv
// Self-checking bench for the muxed bus slave
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic app_irq_i = 1'b0;
    logic [7:0] app_status_i = 8'h00;
    logic [7:0] app_dataout_i = 8'h00;
    logic app_dataout_we_i = 1'b0;
    logic ale_n, rd_n, wr_n, fetch_n, oe, int_n, dwr, early, seen, late;
    logic [7:0] addr_hi, bus, dout, ctrl, datain, rq;
    int n_fail = 0;
    int n_compared = 0;
    int n_pulse = 0;
    mmb_top mmb_top_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_hi_i(addr_hi),
        .low_port_i(bus), .low_port_o(dout), .low_port_oe_o(oe), .ale_n_i(ale_n),
        .program_fetch_strobe_n_i(fetch_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .int_n_o(int_n),
        .app_irq_i(app_irq_i), .app_status_i(app_status_i), .app_dataout_i(app_dataout_i),
        .app_dataout_we_i(app_dataout_we_i), .ctrl_o(ctrl), .datain_o(datain),
        .datain_wr_o(dwr));
    mmb_host_model mmb_host_model_i (.clk_sys_i(clk_sys_i), .dev_data_i(dout),
        .dev_oe_i(oe), .ale_n_o(ale_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .fetch_n_o(fetch_n),
        .addr_hi_o(addr_hi), .bus_o(bus));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i) if (dwr === 1'b1) n_pulse++;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] hi, input logic [7:0] lo,
            input logic [7:0] d, input logic f);
        mmb_host_model_i.cycle(w, hi, lo, d, f, rq, early, seen, late);
    endtask
    task automatic rd_chk(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] exp);
        acc(1'b0, hi, lo, 8'h00, 1'b1);
        check(rq, exp, "read data");
        check({7'h00, early}, 8'h00, "drive before read strobe");
        check({7'h00, seen}, 8'h01, "drive within cycle");
        check({7'h00, late}, 8'h00, "drive after cycle end");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check({5'h00, oe, int_n, dwr}, 8'h02, "reset outputs");
        check(dout, 8'h00, "read data at reset");
        check(ctrl, 8'h00, "ctrl at reset");
        check(datain, 8'h00, "datain at reset");
    endtask
    task automatic t_ctrl();
        acc(1'b1, 8'h00, 8'h82, 8'ha5, 1'b1);
        check(ctrl, 8'ha5, "ctrl write");
        check({7'h00, seen}, 8'h00, "drive in write");
        acc(1'b1, 8'h00, 8'h82, 8'h5a, 1'b1);
        check(ctrl, 8'h5a, "ctrl second write");
        rd_chk(8'h00, 8'h82, 8'h5a);
    endtask
    task automatic t_map();
        app_status_i = 8'h3c;
        rd_chk(8'h00, 8'h80, 8'h3c);
        acc(1'b1, 8'h00, 8'h80, 8'hff, 1'b1);
        rd_chk(8'h00, 8'h80, 8'h3c);
        app_dataout_i = 8'h96;
        app_dataout_we_i = 1'b1;
        @(negedge clk_sys_i);
        app_dataout_we_i = 1'b0;
        rd_chk(8'h00, 8'h86, 8'h96);
        rd_chk(8'h00, 8'h88, 8'h00);
        rd_chk(8'h00, 8'h83, 8'h00);
    endtask
    task automatic t_datain();
        n_pulse = 0;
        acc(1'b1, 8'h00, 8'h84, 8'h77, 1'b1);
        check(datain, 8'h77, "datain write");
        check(8'(n_pulse), 8'h01, "datain pulses");
        check(ctrl, 8'h5a, "ctrl untouched");
    endtask
    task automatic t_select();
        acc(1'b1, 8'h01, 8'h82, 8'h11, 1'b1);
        acc(1'b1, 8'h80, 8'h82, 8'h22, 1'b1);
        check(ctrl, 8'h5a, "write to other device");
        acc(1'b0, 8'h01, 8'h82, 8'h00, 1'b1);
        check({7'h00, seen}, 8'h00, "drive when not selected");
        acc(1'b1, 8'h00, 8'h82, 8'h33, 1'b0);
        check(ctrl, 8'h5a, "write in fetch cycle");
    endtask
    task automatic t_irq();
        @(negedge clk_sys_i);
        app_irq_i = 1'b1;
        @(negedge clk_sys_i);
        check({7'h00, int_n}, 8'h00, "irq asserted");
        app_irq_i = 1'b0;
        @(negedge clk_sys_i);
        check({7'h00, int_n}, 8'h01, "irq released");
    endtask
    task automatic t_reset_mid();
        @(negedge clk_sys_i);
        rstn_i = 1'b0;
        #1;
        check(ctrl, 8'h00, "ctrl in reset");
        check(datain, 8'h00, "datain in reset");
        repeat (8) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        rd_chk(8'h00, 8'h82, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #200us;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (8) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        t_reset();
        t_ctrl();
        t_map();
        t_datain();
        t_select();
        t_irq();
        t_reset_mid();
        end_of_test();
    end
endmodule
